// ===== logic/rsw_pkg.sv
// constants, types and helpers shared by the reset and watchdog block
// assumes a single 20 MHz system clock and an apb bus with 32-bit data
package rsw_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int T_POR_US = 11000;
  localparam int T_WDT_US = 500;
  localparam int T_RSM_NS = 24000;
  localparam int POR_CYC = T_POR_US * CLK_MHZ;
  localparam int WDT_HOLD_CYC = T_WDT_US * CLK_MHZ;
  localparam int RSM_CYC = (T_RSM_NS * CLK_MHZ + 999) / 1000;
  localparam int EXT_PW_CYC = 1 << 13;
  localparam int LV_PD_PW_CYC = 1 << 9;
  localparam int WDT_BASE_LOG2 = 15;
  localparam int WARM_CYC = 64;

  // ----------------------------------------------------------------
  // register map (indexes, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_CLR_KEY = 8'h93;
  localparam logic [7:0] IDX_WDT_CFG = 8'h94;
  localparam logic [7:0] IDX_RES_CFG = 8'h97;
  localparam logic [7:0] IDX_CAUSE = 8'h98;
  localparam logic [7:0] IDX_P0_EN = 8'hA2;
  localparam logic [7:0] IDX_P1_EN = 8'hA3;
  localparam logic [7:0] IDX_P2_EN = 8'hA4;
  localparam logic [7:0] IDX_LPR_CTL = 8'hAF;
  localparam logic [7:0] CLR_KEY_VAL = 8'h55;
  localparam logic [2:0] WDT_SEL_RST = 3'h5;
  localparam logic [1:0] RES_SEL_RST = 2'h0;
  localparam logic PD_LV_EN_RST = 1'h1;
  localparam logic IDLE_WDT_EN_RST = 1'h0;
  localparam int CAUSE_CORE_BIT = 5;
  localparam int CAUSE_CONV_BIT = 4;
  localparam int LPR_IDLE_WDT_BIT = 2;
  localparam int LPR_PD_LV_BIT = 0;
  localparam int NPIN = 20;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rsw_apb_req_t;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HW = 5'h02,
    ST_WDT = 5'h04,
    ST_RSM = 5'h08,
    ST_WARM = 5'h10
  } rsw_state_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

endpackage

// ===== logic/rsw_sync.sv
// two-flop synchroniser for a group of pins
// assumes the pins are asynchronous to clock
module rsw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RV = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_r <= RV;
      q <= RV;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== logic/rsw_wdog.sv
// watchdog counter with selectable overflow length
// assumes clr and run come from logic on the same clock
module rsw_wdog #(
  parameter int SHIFT = rsw_pkg::WDT_BASE_LOG2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic clr,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic ovf
);
  localparam int CW = SHIFT + 8;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] lim;

  // overflow after 2^(shift+sel) periods
  assign lim = CW'((64'h1 << (SHIFT + int'(sel))) - 64'h1);

  always_ff @(posedge clock) begin
    if (srst || clr || ovf) begin
      cnt_r <= '0;
    end else if (run) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ovf <= 1'b0;
    end else begin
      ovf <= run && !clr && (cnt_r == lim - CW'(1));
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_clr_zero;
    clr |=> cnt_r == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("watchdog not cleared");
endmodule

// ===== logic/rsw_top.sv
// reset sources, reset holds, watchdog and resume reset for a small core
// assumes pins and comparators are asynchronous; pd_mode and idle_mode
// come from the power control logic on the same clock, which keeps running
//
// The implementer's own choice: the APB slave port.
module rsw_top #(
  parameter int POR_HOLD_CYC = rsw_pkg::POR_CYC,
  parameter int WDT_HOLD_CYC = rsw_pkg::WDT_HOLD_CYC,
  parameter int EXT_PW_CYC = rsw_pkg::EXT_PW_CYC,
  parameter int WDT_BASE_LOG2 = rsw_pkg::WDT_BASE_LOG2
) (
  input wire logic clock,
  input wire logic srst,
  input wire rsw_pkg::rsw_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic core_lowvolt_detect,
  input wire logic conv_lowvolt_detect,
  input wire logic ext_reset_n,
  input wire logic [rsw_pkg::NPIN-1:0] resume_pins,
  input wire logic idle_mode,
  input wire logic pd_mode,
  output logic cpu_reset,
  output logic hw_reset,
  output logic wdt_reset,
  output logic resume_reset
);
  localparam int CW = $clog2(POR_HOLD_CYC + WDT_HOLD_CYC + rsw_pkg::RSM_CYC + 1);
  localparam int EW = $clog2(EXT_PW_CYC + 1);
  localparam int LW = $clog2(rsw_pkg::LV_PD_PW_CYC + 1);
  localparam int WW = $clog2(rsw_pkg::WARM_CYC + 1);

  // ----------------------------------------------------------------
  // synchronised inputs
  // ----------------------------------------------------------------
  logic [3:0] ana_s;
  logic [rsw_pkg::NPIN-1:0] pin_s;
  logic sup_s, lv1_s, lv2_s, ext_n_s;

  rsw_sync #(.W(4), .RV(4'h9)) u_sync_ana (
    .clock(clock),
    .srst(srst),
    .d({supply_ok, core_lowvolt_detect, conv_lowvolt_detect, ext_reset_n}),
    .q(ana_s)
  );
  rsw_sync #(.W(rsw_pkg::NPIN), .RV('1)) u_sync_pin (
    .clock(clock),
    .srst(srst),
    .d(resume_pins),
    .q(pin_s)
  );
  assign {sup_s, lv1_s, lv2_s, ext_n_s} = ana_s;

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  rsw_pkg::rsw_state_t state_r;
  logic [CW-1:0] hold_r;
  logic [WW-1:0] warm_r;
  logic [EW-1:0] ext_cnt_r;
  logic [LW-1:0] lv_cnt_r;
  logic ext_held_r, pd_prev_r;
  logic [rsw_pkg::NPIN-1:0] pin_prev_r, pin_en_r;
  logic [2:0] wdt_sel_r;
  logic [1:0] res_sel_r;
  logic pd_lv_en_r, idle_wdt_en_r, core_flag_r, conv_flag_r;
  logic lv1_trip, hw_enter, hw_keep, wdt_ovf, rsm_evt, key_wr, wr, setup;
  logic in_run, wdt_run, wdt_clr;
  logic [rsw_pkg::NPIN-1:0] evt;
  logic [31:0] rd_nxt;
  logic map_hit;

  assign in_run = (state_r == rsw_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // hardware reset sources
  // ----------------------------------------------------------------
  // a dip in power-down must persist before it counts
  assign lv1_trip = lv1_s && (!pd_mode ||
    (pd_lv_en_r && lv_cnt_r == LW'(rsw_pkg::LV_PD_PW_CYC - 1)));
  assign hw_enter = lv1_trip || lv2_s || !sup_s || ext_held_r;
  assign hw_keep = lv1_s || lv2_s || !sup_s || ext_held_r;

  always_ff @(posedge clock) begin
    if (srst || !pd_mode || !pd_lv_en_r || !lv1_s) begin
      lv_cnt_r <= '0;
    end else if (lv_cnt_r != LW'(rsw_pkg::LV_PD_PW_CYC - 1)) begin
      lv_cnt_r <= lv_cnt_r + LW'(1);
    end
  end

  // short glitches on the pin never reach the counter's end
  always_ff @(posedge clock) begin
    if (srst || ext_n_s || pd_mode) begin
      ext_cnt_r <= '0;
    end else if (ext_cnt_r != EW'(EXT_PW_CYC)) begin
      ext_cnt_r <= ext_cnt_r + EW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst || ext_n_s) begin
      ext_held_r <= 1'b0;
    end else if (ext_cnt_r == EW'(EXT_PW_CYC) && !pd_mode) begin
      ext_held_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // resume detection
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_prev_r <= '1;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  always_comb begin
    unique case (res_sel_r)
      2'h0: evt = ~pin_s;
      2'h1: evt = pin_s & ~pin_prev_r;
      2'h2: evt = ~pin_s & pin_prev_r;
      default: evt = pin_s ^ pin_prev_r;
    endcase
  end
  assign rsm_evt = pd_mode && |(evt & pin_en_r);

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  assign wdt_run = in_run && !pd_mode && (!idle_mode || idle_wdt_en_r);
  assign wdt_clr = !in_run || key_wr;

  rsw_wdog #(.SHIFT(WDT_BASE_LOG2)) u_wdog (
    .clock(clock),
    .srst(srst),
    .clr(wdt_clr),
    .run(wdt_run),
    .sel(wdt_sel_r),
    .ovf(wdt_ovf)
  );

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // hardware reset wins over every other source at every state
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= rsw_pkg::ST_HW;
      hold_r <= CW'(POR_HOLD_CYC - 1);
    end else if (hw_enter || (state_r == rsw_pkg::ST_HW && hw_keep)) begin
      state_r <= rsw_pkg::ST_HW;
      hold_r <= CW'(POR_HOLD_CYC - 1);
    end else begin
      unique case (state_r)
        rsw_pkg::ST_RUN: begin
          if (wdt_ovf) begin
            state_r <= rsw_pkg::ST_WDT;
            hold_r <= CW'(WDT_HOLD_CYC - 1);
          end else if (rsm_evt) begin
            state_r <= rsw_pkg::ST_RSM;
            hold_r <= CW'(rsw_pkg::RSM_CYC - 1);
          end else if (pd_prev_r && !pd_mode) begin
            state_r <= rsw_pkg::ST_WARM;
          end
        end
        rsw_pkg::ST_RSM: begin
          if (hold_r == '0) begin
            state_r <= rsw_pkg::ST_WARM;
          end else begin
            hold_r <= hold_r - CW'(1);
          end
        end
        rsw_pkg::ST_WARM: begin
          if (warm_r == '0) begin
            state_r <= rsw_pkg::ST_RUN;
          end
        end
        default: begin
          if (hold_r == '0) begin
            state_r <= rsw_pkg::ST_RUN;
          end else begin
            hold_r <= hold_r - CW'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst || state_r != rsw_pkg::ST_WARM) begin
      warm_r <= WW'(rsw_pkg::WARM_CYC - 1);
    end else if (warm_r != '0) begin
      warm_r <= warm_r - WW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pd_prev_r <= 1'b0;
    end else begin
      pd_prev_r <= pd_mode;
    end
  end

  // outputs follow the state one cycle later, from flops
  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_reset <= 1'b1;
      hw_reset <= 1'b1;
      wdt_reset <= 1'b0;
      resume_reset <= 1'b0;
    end else begin
      cpu_reset <= !in_run;
      hw_reset <= state_r == rsw_pkg::ST_HW;
      wdt_reset <= state_r == rsw_pkg::ST_WDT;
      resume_reset <= state_r == rsw_pkg::ST_RSM;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !pslverr;
  assign key_wr = wr && apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_CLR_KEY) &&
    apb_req.pwdata[7:0] == rsw_pkg::CLR_KEY_VAL;

  always_comb begin
    rd_nxt = '0;
    map_hit = 1'b1;
    unique case (apb_req.paddr)
      rsw_pkg::reg_addr(rsw_pkg::IDX_CLR_KEY): rd_nxt = '0;
      rsw_pkg::reg_addr(rsw_pkg::IDX_WDT_CFG): rd_nxt[2:0] = wdt_sel_r;
      rsw_pkg::reg_addr(rsw_pkg::IDX_RES_CFG): rd_nxt[1:0] = res_sel_r;
      rsw_pkg::reg_addr(rsw_pkg::IDX_CAUSE): begin
        rd_nxt[rsw_pkg::CAUSE_CORE_BIT] = core_flag_r;
        rd_nxt[rsw_pkg::CAUSE_CONV_BIT] = conv_flag_r;
      end
      rsw_pkg::reg_addr(rsw_pkg::IDX_P0_EN): rd_nxt[7:0] = pin_en_r[7:0];
      rsw_pkg::reg_addr(rsw_pkg::IDX_P1_EN): rd_nxt[7:0] = pin_en_r[15:8];
      rsw_pkg::reg_addr(rsw_pkg::IDX_P2_EN): rd_nxt[3:0] = pin_en_r[19:16];
      rsw_pkg::reg_addr(rsw_pkg::IDX_LPR_CTL): begin
        rd_nxt[rsw_pkg::LPR_IDLE_WDT_BIT] = idle_wdt_en_r;
        rd_nxt[rsw_pkg::LPR_PD_LV_BIT] = pd_lv_en_r;
      end
      default: map_hit = 1'b0;
    endcase
  end

  // zero wait states: the answer is ready in the first access cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !map_hit;
      prdata <= (setup && !apb_req.pwrite) ? rd_nxt : '0;
    end
  end

  // fields reset by hardware or watchdog reset, kept across resume reset
  always_ff @(posedge clock) begin
    if (srst || state_r == rsw_pkg::ST_HW || state_r == rsw_pkg::ST_WDT) begin
      wdt_sel_r <= rsw_pkg::WDT_SEL_RST;
      res_sel_r <= rsw_pkg::RES_SEL_RST;
      pin_en_r <= '0;
    end else if (wr) begin
      if (apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_WDT_CFG))
        wdt_sel_r <= apb_req.pwdata[2:0];
      if (apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_RES_CFG))
        res_sel_r <= apb_req.pwdata[1:0];
      if (apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_P0_EN))
        pin_en_r[7:0] <= apb_req.pwdata[7:0];
      if (apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_P1_EN))
        pin_en_r[15:8] <= apb_req.pwdata[7:0];
      if (apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_P2_EN))
        pin_en_r[19:16] <= apb_req.pwdata[3:0];
    end
  end

  // enables reset by hardware or resume reset, kept across watchdog reset
  always_ff @(posedge clock) begin
    if (srst || state_r == rsw_pkg::ST_HW || state_r == rsw_pkg::ST_RSM) begin
      pd_lv_en_r <= rsw_pkg::PD_LV_EN_RST;
      idle_wdt_en_r <= rsw_pkg::IDLE_WDT_EN_RST;
    end else if (wr && apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_LPR_CTL)) begin
      pd_lv_en_r <= apb_req.pwdata[rsw_pkg::LPR_PD_LV_BIT];
      idle_wdt_en_r <= apb_req.pwdata[rsw_pkg::LPR_IDLE_WDT_BIT];
    end
  end

  // cause flags: write one to clear, a new trip in the same cycle wins
  always_ff @(posedge clock) begin
    if (srst) begin
      core_flag_r <= 1'b0;
      conv_flag_r <= 1'b0;
    end else begin
      if (lv1_trip) begin
        core_flag_r <= 1'b1;
      end else if (wr && apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_CAUSE) &&
                   apb_req.pwdata[rsw_pkg::CAUSE_CORE_BIT]) begin
        core_flag_r <= 1'b0;
      end
      if (lv2_s) begin
        conv_flag_r <= 1'b1;
      end else if (wr && apb_req.paddr == rsw_pkg::reg_addr(rsw_pkg::IDX_CAUSE) &&
                   apb_req.pwdata[rsw_pkg::CAUSE_CONV_BIT]) begin
        conv_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_core_flag;
    lv1_trip |=> core_flag_r && state_r == rsw_pkg::ST_HW;
  endproperty
  a_core_flag: assert property (p_core_flag) else $error("core trip lost");
  property p_conv_flag;
    lv2_s |=> conv_flag_r ##1 cpu_reset;
  endproperty
  a_conv_flag: assert property (p_conv_flag) else $error("conv trip lost");
  property p_hw_hold;
    state_r == rsw_pkg::ST_HW && hw_keep |=> state_r == rsw_pkg::ST_HW [*2];
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("hw hold ended early");
  property p_pd_lv;
    pd_mode && !pd_lv_en_r |-> !lv1_trip;
  endproperty
  a_pd_lv: assert property (p_pd_lv) else $error("pd lv not gated");
  property p_pd_ext;
    pd_mode && in_run |=> !ext_held_r && ext_cnt_r == '0;
  endproperty
  a_pd_ext: assert property (p_pd_ext) else $error("pin acted in pd");
  property p_wdt_rst;
    in_run && wdt_ovf && !hw_enter |=> state_r == rsw_pkg::ST_WDT ##1 wdt_reset;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("no wdt reset");
  property p_wdt_sel;
    state_r == rsw_pkg::ST_WDT |=> wdt_sel_r == 3'h5 && $stable(pd_lv_en_r);
  endproperty
  a_wdt_sel: assert property (p_wdt_sel) else $error("wdt reset fields");
  property p_rsm_keep;
    state_r == rsw_pkg::ST_RSM |=> $stable(wdt_sel_r) && $stable(res_sel_r);
  endproperty
  a_rsm_keep: assert property (p_rsm_keep) else $error("resume lost fields");
  property p_rsm_go;
    in_run && rsm_evt && !hw_enter && !wdt_ovf |=> state_r == rsw_pkg::ST_RSM ##1 resume_reset;
  endproperty
  a_rsm_go: assert property (p_rsm_go) else $error("no resume reset");
  property p_idle_stop;
    idle_mode && !idle_wdt_en_r |-> !wdt_run;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("wdt ran in idle");

  c_wdt: cover property (state_r == rsw_pkg::ST_WDT ##1 state_r == rsw_pkg::ST_RUN);
  c_rsm: cover property (state_r == rsw_pkg::ST_RSM ##1 state_r == rsw_pkg::ST_WARM);
  c_ext: cover property ($rose(ext_held_r));
endmodule

// ===== dv/rsw_far_model.sv
// far-side model: supply monitors, reset pin and resume pins
// assumes calls are made right after a rising edge of clock
module rsw_far_model (
  input wire logic clock,
  output logic supply_ok,
  output logic core_lowvolt_detect,
  output logic conv_lowvolt_detect,
  output logic ext_reset_n,
  output logic [rsw_pkg::NPIN-1:0] resume_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // idle levels: supply good, no dip, pin released, pins pulled high
  // ----------------------------------------------------------------
  initial begin
    supply_ok = 1'b1;
    core_lowvolt_detect = 1'b0;
    conv_lowvolt_detect = 1'b0;
    ext_reset_n = 1'b1;
    resume_pins = '1;
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  // a comparator dip of n clocks; which 0 is the core monitor
  task automatic dip(input int which, input int n);
    if (which == 0) begin
      core_lowvolt_detect <= 1'b1;
    end else begin
      conv_lowvolt_detect <= 1'b1;
    end
    repeat (n) @(posedge clock);
    core_lowvolt_detect <= 1'b0;
    conv_lowvolt_detect <= 1'b0;
  endtask

  task automatic pin_low(input int n);
    ext_reset_n <= 1'b0;
    repeat (n) @(posedge clock);
    ext_reset_n <= 1'b1;
  endtask

  task automatic set_pin(input int i, input logic v);
    resume_pins[i] <= v;
  endtask
endmodule

// ===== dv/reset_sources_and_watchdog_tb.sv
// self-checking bench for the reset and watchdog block
// assumes shortened holds: por 200, watchdog 50, pin width 32, base 2^6
module reset_sources_and_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_H = 200;
  localparam int WDT_H = 50;
  localparam int PIN_PW = 32;
  logic clock, srst, pready, pslverr, idle_mode, pd_mode;
  logic supply_ok, core_lv, conv_lv, ext_reset_n;
  logic cpu_reset, hw_reset, wdt_reset, resume_reset;
  logic [31:0] prdata;
  logic [rsw_pkg::NPIN-1:0] resume_pins;
  rsw_pkg::rsw_apb_req_t apb_req;
  int bad_count, checked, cyc, n;

  rsw_top #(.POR_HOLD_CYC(POR_H), .WDT_HOLD_CYC(WDT_H), .EXT_PW_CYC(PIN_PW),
    .WDT_BASE_LOG2(6)) dut (.clock(clock), .srst(srst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
    .core_lowvolt_detect(core_lv), .conv_lowvolt_detect(conv_lv),
    .ext_reset_n(ext_reset_n), .resume_pins(resume_pins), .idle_mode(idle_mode),
    .pd_mode(pd_mode), .cpu_reset(cpu_reset), .hw_reset(hw_reset),
    .wdt_reset(wdt_reset), .resume_reset(resume_reset));

  rsw_far_model far (.clock(clock), .supply_ok(supply_ok), .core_lowvolt_detect(core_lv),
    .conv_lowvolt_detect(conv_lv), .ext_reset_n(ext_reset_n), .resume_pins(resume_pins));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  // one apb transfer; the gap edge keeps back-to-back calls legal
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int k;
    k = 0;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= {2'h0, idx, 2'h0};
    apb_req.pwdata <= d;
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic rise(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge clock);
      k++;
    end
  endtask

  task automatic len(ref logic s, output int k);
    k = 0;
    while (s === 1'b1 && k < 5000) begin
      @(posedge clock);
      k++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(rsw_pkg::IDX_WDT_CFG, 32'h5);
    rd(rsw_pkg::IDX_RES_CFG, 32'h0);
    rd(rsw_pkg::IDX_LPR_CTL, 32'h1);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask

  task automatic t_lv(input int which);
    wr(rsw_pkg::IDX_CLR_KEY, 32'h55);
    far.dip(which, 20);
    chk({31'h0, hw_reset}, 32'h1);
    len(cpu_reset, n);
    rng(n, POR_H, POR_H + 8);
    rd(rsw_pkg::IDX_CAUSE, (which == 0) ? 32'h20 : 32'h10);
    wr(rsw_pkg::IDX_CAUSE, 32'h30);
    rd(rsw_pkg::IDX_CAUSE, 32'h0);
  endtask

  // dip in power-down must outlast 2^9 clocks
  // the register writes between dips let the monitor settle low again
  task automatic t_pd_lv();
    pd_mode <= 1'b1;
    far.dip(0, 480);
    chk({31'h0, hw_reset}, 32'h0);
    wr(rsw_pkg::IDX_LPR_CTL, 32'h0);
    far.dip(0, 540);
    chk({31'h0, hw_reset}, 32'h0);
    wr(rsw_pkg::IDX_LPR_CTL, 32'h1);
    far.dip(0, 540);
    pd_mode <= 1'b0;
    chk({31'h0, hw_reset}, 32'h1);
    len(cpu_reset, n);
    rng(n, POR_H, POR_H + 8);
  endtask

  task automatic t_pin();
    far.pin_low(PIN_PW - 6);
    repeat (6) @(posedge clock);
    chk({31'h0, hw_reset}, 32'h0);
    far.pin_low(PIN_PW + 12);
    chk({31'h0, hw_reset}, 32'h1);
    len(cpu_reset, n);
    rng(n, POR_H, POR_H + 8);
    pd_mode <= 1'b1;
    far.pin_low(PIN_PW + 12);
    repeat (4) @(posedge clock);
    chk({30'h0, hw_reset, cpu_reset}, 32'h0);
    pd_mode <= 1'b0;
    rise(cpu_reset, 5, n);
    len(cpu_reset, n);
    rng(n, 62, 66);
  endtask

  task automatic t_wdt();
    wr(rsw_pkg::IDX_LPR_CTL, 32'h4);
    wr(rsw_pkg::IDX_WDT_CFG, 32'h0);
    repeat (4) begin
      repeat (40) @(posedge clock);
      wr(rsw_pkg::IDX_CLR_KEY, 32'h55);
    end
    chk({31'h0, wdt_reset}, 32'h0);
    wr(rsw_pkg::IDX_CLR_KEY, 32'h54);
    rise(wdt_reset, 100, n);
    rng(n, 56, 70);
    chk({31'h0, cpu_reset}, 32'h1);
    len(wdt_reset, n);
    rng(n, WDT_H - 1, WDT_H + 3);
    rd(rsw_pkg::IDX_WDT_CFG, 32'h5);
    rd(rsw_pkg::IDX_LPR_CTL, 32'h4);
    rise(wdt_reset, 3000, n);
    rng(n, 2030, 2056);
    len(wdt_reset, n);
  endtask

  task automatic t_idle(input logic en);
    wr(rsw_pkg::IDX_LPR_CTL, {29'h0, en, 2'h1});
    wr(rsw_pkg::IDX_WDT_CFG, 32'h0);
    wr(rsw_pkg::IDX_CLR_KEY, 32'h55);
    idle_mode <= 1'b1;
    rise(wdt_reset, en ? 100 : 150, n);
    chk({31'h0, wdt_reset}, {31'h0, en});
    idle_mode <= 1'b0;
    rise(wdt_reset, 100, n);
    len(wdt_reset, n);
  endtask

  // idle level of pin 0 is the one that does not trigger the mode
  task automatic t_resume(input logic [1:0] m);
    logic idle;
    idle = (m == 2'h1 || m == 2'h3) ? 1'b0 : 1'b1;
    wr(rsw_pkg::IDX_RES_CFG, {30'h0, m});
    wr(rsw_pkg::IDX_P0_EN, 32'h1);
    wr(rsw_pkg::IDX_LPR_CTL, 32'h4);
    far.set_pin(0, idle);
    repeat (4) @(posedge clock);
    pd_mode <= 1'b1;
    far.set_pin(1, 1'b0);
    repeat (10) @(posedge clock);
    chk({31'h0, resume_reset}, 32'h0);
    far.set_pin(0, ~idle);
    rise(resume_reset, 10, n);
    pd_mode <= 1'b0;
    chk({31'h0, resume_reset}, 32'h1);
    len(resume_reset, n);
    rng(n, rsw_pkg::RSM_CYC - 2, rsw_pkg::RSM_CYC + 4);
    len(cpu_reset, n);
    rng(n, 62, 68);
    rd(rsw_pkg::IDX_RES_CFG, {30'h0, m});
    rd(rsw_pkg::IDX_LPR_CTL, 32'h1);
    far.set_pin(1, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    bad_count = 0;
    checked = 0;
    cyc = 0;
    srst = 1'b1;
    apb_req = '0;
    idle_mode = 1'b0;
    pd_mode = 1'b0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    len(cpu_reset, n);
    rng(n, POR_H - 2, POR_H + 6);
    t_regs();
    t_lv(0);
    t_lv(1);
    t_pd_lv();
    t_pin();
    t_wdt();
    t_idle(1'b1);
    t_idle(1'b0);
    for (int m = 0; m < 4; m++) begin
      t_resume(m[1:0]);
    end
    summarize();
  end
endmodule
